// File: pkg/lehp_map.svh
// Offsets, field positions, reset values and pin-vector layout for the lookup engine host port.
// Included by the design; holds definitions only.
`ifndef LEHP_MAP_SVH
`define LEHP_MAP_SVH

// APB register byte offsets
`define LEHP_OFF_CONFIG 8'h00
`define LEHP_OFF_DEVSEL 8'h04
`define LEHP_OFF_STATUS 8'h08
`define LEHP_OFF_INSTR 8'h0c

// Configuration register fields
`define LEHP_CFG_MASK_HI 31
`define LEHP_CFG_MASK_LO 29
`define LEHP_CFG_MODE_HI 27
`define LEHP_CFG_MODE_LO 26
`define LEHP_CFG_LOWEST 25
`define LEHP_CFG_PAGE_HI 3
`define LEHP_CFG_RESET 32'h0000_0000
`define LEHP_MODE_HARD 2'h0
`define LEHP_MODE_SOFT 2'h3

// Device select register: page in 3..0, compare enable (active low) in bit 4
`define LEHP_DS_EN_N 4
`define LEHP_DS_RESET 32'h0000_0010

// Instruction register layout
`define LEHP_INS_OP_HI 5
`define LEHP_INS_MASK_HI 8
`define LEHP_INS_MASK_LO 6
`define LEHP_INS_SEG 12
`define LEHP_INS_DIR 13
`define LEHP_INS_RESET 14'h0000

// Status register result types
`define LEHP_TYPE_RESET 2'h0
`define LEHP_TYPE_MATCH 2'h1
`define LEHP_TYPE_MEM 2'h2

// Operation codes on the opcode lines
`define LEHP_OP_CMP 6'h01
`define LEHP_OP_WR_NF 6'h02
`define LEHP_OP_TOP 6'h03
`define LEHP_OP_MEM_IND 6'h04
`define LEHP_OP_REG 6'h05
`define LEHP_OP_VALID 6'h06
`define LEHP_OP_PAGE 6'h07

// Synchronised pin vector layout
`define LEHP_PIN_W 55
`define LEHP_P_EN_N 54
`define LEHP_P_OE_N 53
`define LEHP_P_WR_N 52
`define LEHP_P_CS1_N 51
`define LEHP_P_CS2_N 50
`define LEHP_P_QUAL_N 49
`define LEHP_P_SEG 48
`define LEHP_P_VB_N 47
`define LEHP_P_MIN_N 46
`define LEHP_P_FIN_N 45
`define LEHP_P_AC_HI 44
`define LEHP_P_AC_LO 32

`endif

// File: pkg/lehp_pkg.sv
// Types shared by the lookup engine host port.
// Assumes nothing beyond a SystemVerilog compiler.
package lehp_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DONE = 4'b1000
  } lehp_state_t;

  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_CMP = 3'h1,
    CLS_NF = 3'h2,
    CLS_TOP = 3'h3,
    CLS_MEM = 3'h4
  } lehp_class_t;

endpackage : lehp_pkg

// File: hdl/lehp_host_port.sv
// Host-side control port of a 64-bit associative lookup engine: pin decode, software
// instruction register, active-address output drive, APB register access.
// Assumes the array core answers each coreReq with one coreDone pulse; pins are asynchronous.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "lehp_map.svh"

// Behaviour
// (RULE1) Qualifier low: segment and bus form an array address; high: control information.
// (RULE2) Host decode drives qualifier high inside the mapped control range only.
// (RULE3) Enabled by either select low, or device select page match with enable.
// (RULE4) Validity line acts as an extra data bit on array reads and writes.
// (RULE5) Write stores validity level, read drives it; low valid, high empty.
// (RULE6) Mode both low hardware, both high software; software qualifier-high read returns status.
// (RULE7) Segment select low picks lower 32 bits, high picks upper 32 bits.
// (RULE8) Hardware control: lines 8-6 pick mask register, lines 5-0 the opcode.
// (RULE9) Software qualifier-high write loads instruction from data 11-0; bit 12 is segment.
// (RULE10) Software: data bit 13 at cycle start replaces write strobe.
// (RULE11) Instructions needing no data execute in the loading cycle.
// (RULE12) Data-carrying instructions execute on the next qualifier-low data cycle.
// (RULE13) Loaded instruction persists for every later qualifier-low data cycle.
// (RULE14) Host follows each instruction with the cycle type it expects.
// (RULE15) Host loads compare once, then alternates comparand writes and status reads.
// (RULE16) After cascade operations only the top device, or lowest on mismatch, drives status.
// (RULE17) After random access every selected device drives status; host selects one.
// (RULE18) Active address shows the address from the latest control state changing it.
// (RULE19) After a match only the top-priority matching device drives active address.
// (RULE20) No match anywhere: lowest-priority device drives all ones, others float.
// (RULE21) After next-free write only the written device drives that address.
// (RULE22) System full: write suppressed, lowest-priority device drives all ones.
// (RULE23) Active address changes only while strobe high, latched once it goes low.
// (RULE24) Output-enable input high keeps active address high-impedance.
// (RULE25) Other mode values act as hardware control.
module lehp_host_port #(
  parameter int AW = 13
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_n,
  input wire logic output_enable_n,
  input wire logic write_n,
  input wire logic select_one_n,
  input wire logic select_two_n,
  input wire logic address_qualifier_n,
  input wire logic segment_select,
  input wire logic [AW-1:0] addr_ctrl_bus,
  input wire logic match_in_n,
  input wire logic full_in_n,
  input wire logic [31:0] data_lines_in,
  output logic [31:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic validity_line_n_in,
  output logic validity_line_n_out,
  output logic validity_line_oe,
  output logic [AW+3:0] active_address_out,
  output logic active_address_oe,
  output logic coreReq,
  output logic [5:0] coreOp,
  output logic [2:0] coreMask,
  output logic [AW-1:0] coreAddr,
  output logic coreDirect,
  output logic coreSeg,
  output logic coreWrite,
  output logic [31:0] coreWData,
  output logic coreValidN,
  input wire logic coreDone,
  input wire logic coreHit,
  input wire logic coreMultiN,
  input wire logic coreFullN,
  input wire logic coreWrote,
  input wire logic [AW-1:0] coreResAddr,
  input wire logic [31:0] coreRdData,
  input wire logic coreRdValidN
);

  localparam int PW = `LEHP_PIN_W;

  logic [PW-1:0] pinMeta;
  logic [PW-1:0] pinSync;
  logic enPrev;
  logic [31:0] config_q;
  logic [31:0] devSel;
  logic [13:0] instr;
  lehp_pkg::lehp_state_t state;
  lehp_pkg::lehp_class_t cls;
  lehp_pkg::lehp_class_t lastCls;
  logic isRead;
  logic isStatus;
  logic memData;
  logic [AW+3:0] aaPend;
  logic aaOwn;
  logic [1:0] resType;
  logic matchN;
  logic multiN;
  logic fullN;
  logic apbAccess;

  // Decode of the cycle seen at the strobe's falling edge
  logic cycStart;
  logic selected;
  logic softMode;
  logic qualHigh;
  logic wrCycle;
  logic [31:0] dq;
  logic [AW-1:0] ac;
  logic [13:0] next_instr;
  logic loadInstr;
  logic doCore;
  logic doStatus;
  logic [5:0] op;
  logic [2:0] mask;
  logic seg;
  logic wr;
  logic direct;
  lehp_pkg::lehp_class_t opCls;

  function automatic lehp_pkg::lehp_class_t lehp_op_class(input logic [5:0] o);
    case (o)
      `LEHP_OP_CMP: lehp_op_class = lehp_pkg::CLS_CMP;
      `LEHP_OP_WR_NF: lehp_op_class = lehp_pkg::CLS_NF;
      `LEHP_OP_TOP: lehp_op_class = lehp_pkg::CLS_TOP;
      `LEHP_OP_MEM_IND: lehp_op_class = lehp_pkg::CLS_MEM;
      default: lehp_op_class = lehp_pkg::CLS_NONE;
    endcase
  endfunction : lehp_op_class

  function automatic logic lehp_needs_data(input logic [5:0] o);
    lehp_needs_data = (o == `LEHP_OP_MEM_IND) || (o == `LEHP_OP_REG) || (o == `LEHP_OP_VALID) ||
      (o == `LEHP_OP_PAGE);
  endfunction : lehp_needs_data

  // Two-stage synchroniser on every pin input
  always_ff @(posedge clock) begin
    pinMeta <= {enable_n, output_enable_n, write_n, select_one_n, select_two_n, address_qualifier_n,
      segment_select, validity_line_n_in, match_in_n, full_in_n, addr_ctrl_bus, data_lines_in};
    pinSync <= pinMeta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      enPrev <= 1'b1;
    end else begin
      enPrev <= pinSync[`LEHP_P_EN_N];
    end
  end

  always_comb begin
    cycStart = enPrev && !pinSync[`LEHP_P_EN_N] && (state == lehp_pkg::ST_IDLE);
    selected = !pinSync[`LEHP_P_CS1_N] || !pinSync[`LEHP_P_CS2_N] ||
      (!devSel[`LEHP_DS_EN_N] && devSel[3:0] == config_q[`LEHP_CFG_PAGE_HI:0]); // [RULE3]
    // Only the all-high pattern selects software control [RULE6] [RULE25]
    softMode = config_q[`LEHP_CFG_MODE_HI:`LEHP_CFG_MODE_LO] == `LEHP_MODE_SOFT;
    qualHigh = pinSync[`LEHP_P_QUAL_N];
    wrCycle = !pinSync[`LEHP_P_WR_N];
    dq = pinSync[31:0];
    ac = pinSync[`LEHP_P_AC_HI:`LEHP_P_AC_LO];
    next_instr = instr;
    loadInstr = 1'b0;
    doCore = 1'b0;
    doStatus = 1'b0;
    op = 6'h00;
    mask = config_q[`LEHP_CFG_MASK_HI:`LEHP_CFG_MASK_LO];
    seg = pinSync[`LEHP_P_SEG]; // [RULE7]
    wr = wrCycle;
    direct = 1'b0;
    if (softMode) begin
      if (qualHigh && wrCycle) begin
        loadInstr = 1'b1;
        next_instr = dq[13:0]; // [RULE9]
        if (!lehp_needs_data(dq[`LEHP_INS_OP_HI:0])) begin
          doCore = 1'b1; // [RULE11]
          op = dq[`LEHP_INS_OP_HI:0];
          mask = dq[`LEHP_INS_MASK_HI:`LEHP_INS_MASK_LO];
          seg = dq[`LEHP_INS_SEG];
          wr = !dq[`LEHP_INS_DIR]; // [RULE10]
        end
      end else if (qualHigh) begin
        doStatus = 1'b1; // [RULE6]
      end else if (lehp_needs_data(instr[`LEHP_INS_OP_HI:0])) begin
        // Persisting instruction runs on each data cycle [RULE12] [RULE13]
        doCore = 1'b1;
        op = instr[`LEHP_INS_OP_HI:0];
        mask = instr[`LEHP_INS_MASK_HI:`LEHP_INS_MASK_LO];
        seg = instr[`LEHP_INS_SEG];
      end
    end else if (qualHigh) begin
      doCore = 1'b1;
      op = ac[5:0]; // [RULE8]
      mask = ac[8:6];
      // Control read with qualifier high in hardware mode: plain control state
    end else begin
      doCore = 1'b1; // [RULE1]
      direct = 1'b1;
    end
    opCls = direct ? lehp_pkg::CLS_MEM : lehp_op_class(op);
  end

  // Cycle sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= lehp_pkg::ST_IDLE;
      cls <= lehp_pkg::CLS_NONE;
      isRead <= 1'b0;
      isStatus <= 1'b0;
      memData <= 1'b0;
    end else begin
      case (state)
        lehp_pkg::ST_IDLE: begin
          if (cycStart && selected && doCore) begin
            state <= lehp_pkg::ST_WAIT;
            cls <= opCls;
            // Never drive the data lines back during a host write cycle, even for a read-type load
            isRead <= !wrCycle;
            isStatus <= 1'b0;
            memData <= direct || op == `LEHP_OP_MEM_IND || op == `LEHP_OP_VALID;
          end else if (cycStart && selected && doStatus) begin
            state <= lehp_pkg::ST_HOLD;
            cls <= lehp_pkg::CLS_NONE;
            isRead <= 1'b1;
            isStatus <= 1'b1;
            memData <= 1'b0;
          end
        end
        lehp_pkg::ST_WAIT: begin
          if (coreDone) begin
            state <= lehp_pkg::ST_HOLD;
          end
        end
        lehp_pkg::ST_HOLD: begin
          if (pinSync[`LEHP_P_EN_N]) begin
            state <= lehp_pkg::ST_DONE;
          end
        end
        lehp_pkg::ST_DONE: begin
          state <= lehp_pkg::ST_IDLE;
        end
        default: begin
          state <= lehp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Software instruction register
  always_ff @(posedge clock) begin
    if (rst) begin
      instr <= `LEHP_INS_RESET;
    end else if (cycStart && selected && loadInstr) begin
      instr <= next_instr; // [RULE9]
    end
  end

  // Request to the array core
  always_ff @(posedge clock) begin
    if (rst) begin
      coreReq <= 1'b0;
      coreOp <= 6'h00;
      coreMask <= 3'h0;
      coreAddr <= '0;
      coreDirect <= 1'b0;
      coreSeg <= 1'b0;
      coreWrite <= 1'b0;
      coreWData <= 32'h0000_0000;
      coreValidN <= 1'b1;
    end else begin
      coreReq <= cycStart && selected && doCore;
      if (cycStart && selected && doCore) begin
        coreOp <= op;
        coreMask <= mask;
        coreAddr <= ac;
        coreDirect <= direct;
        coreSeg <= seg; // [RULE7]
        coreWrite <= wr;
        coreWData <= dq;
        coreValidN <= pinSync[`LEHP_P_VB_N]; // [RULE4] [RULE5]
      end
    end
  end

  // Result capture; the pin value follows later, only while the strobe is high
  always_ff @(posedge clock) begin
    if (rst) begin
      aaPend <= '1;
      aaOwn <= 1'b0;
      resType <= `LEHP_TYPE_RESET;
      lastCls <= lehp_pkg::CLS_NONE;
      matchN <= 1'b1;
      multiN <= 1'b1;
      fullN <= 1'b1;
    end else if (state == lehp_pkg::ST_WAIT && coreDone) begin
      case (cls)
        lehp_pkg::CLS_CMP, lehp_pkg::CLS_TOP: begin
          matchN <= !coreHit;
          multiN <= coreMultiN;
          lastCls <= cls;
          resType <= `LEHP_TYPE_MATCH;
          if (coreHit) begin
            aaPend <= {config_q[`LEHP_CFG_PAGE_HI:0], coreResAddr}; // [RULE18]
            aaOwn <= pinSync[`LEHP_P_MIN_N]; // [RULE19]
          end else begin
            aaPend <= '1;
            aaOwn <= config_q[`LEHP_CFG_LOWEST] && pinSync[`LEHP_P_MIN_N]; // [RULE20]
          end
        end
        lehp_pkg::CLS_NF: begin
          fullN <= coreFullN;
          lastCls <= cls;
          resType <= `LEHP_TYPE_MEM;
          if (coreWrote) begin
            aaPend <= {config_q[`LEHP_CFG_PAGE_HI:0], coreResAddr}; // [RULE21]
            aaOwn <= 1'b1;
          end else begin
            aaPend <= '1; // [RULE22]
            aaOwn <= config_q[`LEHP_CFG_LOWEST] && !pinSync[`LEHP_P_FIN_N];
          end
        end
        lehp_pkg::CLS_MEM: begin
          lastCls <= cls;
          resType <= `LEHP_TYPE_MEM;
          aaPend <= {config_q[`LEHP_CFG_PAGE_HI:0], coreResAddr}; // [RULE18]
          aaOwn <= 1'b1;
        end
        default: begin
          // Register writes and the like leave the address untouched
        end
      endcase
    end
  end

  // Pins update only while the strobe is high [RULE23]; output enable high floats the bus [RULE24]
  always_ff @(posedge clock) begin
    if (rst) begin
      active_address_out <= '1;
      active_address_oe <= 1'b0;
    end else if (pinSync[`LEHP_P_EN_N]) begin
      active_address_out <= aaPend;
      active_address_oe <= aaOwn && !pinSync[`LEHP_P_OE_N];
    end else begin
      active_address_oe <= active_address_oe && !pinSync[`LEHP_P_OE_N]; // [RULE24]
    end
  end

  // Data and validity drive during a read, released when the strobe rises
  always_ff @(posedge clock) begin
    if (rst) begin
      data_lines_out <= 32'h0000_0000;
      data_lines_oe <= 1'b0;
      validity_line_n_out <= 1'b1;
      validity_line_oe <= 1'b0;
    end else if (state == lehp_pkg::ST_WAIT && coreDone && isRead) begin
      data_lines_out <= coreRdData;
      data_lines_oe <= 1'b1;
      validity_line_n_out <= coreRdValidN; // [RULE5]
      validity_line_oe <= memData; // [RULE4]
    end else if (state == lehp_pkg::ST_IDLE && cycStart && selected && doStatus) begin
      data_lines_out <= {1'b0, matchN, multiN, fullN, 2'h0, resType, 4'h0,
        config_q[`LEHP_CFG_PAGE_HI:0], 3'h0, aaPend[AW-1:0]};
      // Cascade results: owner only [RULE16]; random access: any selected device [RULE17]
      data_lines_oe <= (lastCls == lehp_pkg::CLS_MEM) || (lastCls == lehp_pkg::CLS_NONE) || aaOwn;
    end else if (state == lehp_pkg::ST_DONE) begin
      data_lines_oe <= 1'b0;
      validity_line_oe <= 1'b0;
    end
  end

  // APB slave: one wait state, pready from a flop
  assign apbAccess = psel && penable && pready;

  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      config_q <= `LEHP_CFG_RESET;
      devSel <= `LEHP_DS_RESET;
    end else if (apbAccess && pwrite) begin
      if (paddr == `LEHP_OFF_CONFIG) begin
        config_q <= pwdata;
      end
      if (paddr == `LEHP_OFF_DEVSEL) begin
        devSel <= {27'h0, pwdata[4:0]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= 1'b0;
      case (paddr)
        `LEHP_OFF_CONFIG: prdata <= config_q;
        `LEHP_OFF_DEVSEL: prdata <= devSel;
        `LEHP_OFF_STATUS: prdata <= {1'b0, matchN, multiN, fullN, 2'h0, resType, 4'h0,
          config_q[`LEHP_CFG_PAGE_HI:0], 3'h0, aaPend[AW-1:0]};
        `LEHP_OFF_INSTR: prdata <= {18'h0, instr};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pslverr <= 1'b0;
    end
  end

endmodule : lehp_host_port

// File: tb/lehp_core_model.sv
// Behavioural array core that answers each request of the host port.
// Driven by knobs from the bench; its results mean something only while coreDone is high.
`timescale 1ns/10ps
module lehp_core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic coreReq,
  input wire logic slow,
  input wire logic hit,
  input wire logic wrote,
  input wire logic full_in_n,
  input wire logic rdValidN,
  input wire logic [12:0] resAddr,
  input wire logic [31:0] rdData,
  output logic coreDone,
  output logic coreHit,
  output logic coreMultiN,
  output logic coreFullN,
  output logic coreWrote,
  output logic coreRdValidN,
  output logic [12:0] coreResAddr,
  output logic [31:0] coreRdData
);
  int cnt;
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt <= 0;
      coreDone <= 1'b0;
    end else begin
      coreDone <= (cnt == 1);
      cnt <= coreReq ? (slow ? 3 : 1) : (cnt > 0 ? cnt - 1 : 0);
    end
  end
  // Inverted outside the answer cycle, so a result sampled at the wrong time shows up
  assign coreHit = coreDone ? hit : !hit;
  assign coreMultiN = coreDone;
  assign coreFullN = coreDone ? full_in_n : !full_in_n;
  assign coreWrote = coreDone ? wrote : !wrote;
  assign coreRdValidN = coreDone ? rdValidN : !rdValidN;
  assign coreResAddr = coreDone ? resAddr : ~resAddr;
  assign coreRdData = coreDone ? rdData : ~rdData;
endmodule : lehp_core_model

// File: tb/lehp_host_port_sva.sv
// Timing checker for the host port, watching its ports only.
// Bound to every host port instance; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module lehp_host_port_chk #(
  parameter int AW = 13
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_n,
  input wire logic output_enable_n,
  input wire logic data_lines_oe,
  input wire logic [AW+3:0] active_address_out,
  input wire logic active_address_oe,
  input wire logic coreReq,
  input wire logic [5:0] coreOp,
  input wire logic [AW-1:0] coreAddr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_strobe_low; !enable_n [*4]; endsequence
  sequence s_strobe_high; enable_n [*7]; endsequence
  property p_rst; disable iff (1'b0) rst |=> active_address_out == '1 && !active_address_oe && !coreReq; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_pready_pulse; pready |=> !pready; endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_slverr; pready && psel && paddr > 8'h0c |-> pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_req_hold; coreReq |=> (!coreReq && $stable(coreOp) && $stable(coreAddr)) [*3]; endproperty
  a_req_hold: assert property (p_req_hold) else $error("core request not held");
  property p_req_strobe; coreReq |-> !enable_n && !$past(enable_n, 3); endproperty
  a_req_strobe: assert property (p_req_strobe) else $error("core request outside a strobe");
  property p_aa_latch; s_strobe_low |-> $stable(active_address_out); endproperty
  a_aa_latch: assert property (p_aa_latch) else $error("active address moved during strobe");
  property p_aa_move; $changed(active_address_out) |-> $past(enable_n, 2) || $past(enable_n, 3) || $past(rst); endproperty
  a_aa_move: assert property (p_aa_move) else $error("active address changed while latched");
  property p_oe_off; (output_enable_n && enable_n) [*4] |-> !active_address_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("active address driven with enable high");
  property p_oe_cause;
    active_address_oe |-> !output_enable_n || !$past(output_enable_n, 1) || !$past(output_enable_n, 2)
      || !$past(output_enable_n, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("active address driven without enable");
  property p_rd_oe; $rose(data_lines_oe) |-> !enable_n; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("data lines driven outside a cycle");
  property p_dq_release; s_strobe_high |-> !data_lines_oe; endproperty
  a_dq_release: assert property (p_dq_release) else $error("data lines not released");
endmodule : lehp_host_port_chk
bind lehp_host_port lehp_host_port_chk #(.AW(AW)) lehp_host_port_chk_i (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .enable_n(enable_n),
  .output_enable_n(output_enable_n), .data_lines_oe(data_lines_oe), .active_address_out(active_address_out),
  .active_address_oe(active_address_oe), .coreReq(coreReq), .coreOp(coreOp), .coreAddr(coreAddr));

// File: tb/lehp_host_port_tb.sv
// Self-checking bench for the host port: APB master, host pin driver, core model, request queue.
// Assumes the design defaults (13-bit address bus) and the core model beside it.
`timescale 1ns/10ps
`include "lehp_map.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module lehp_host_port_tb;
  typedef struct packed {
    logic dr; logic wr; logic sg; logic cw; logic [12:0] ad; logic [5:0] op; logic [2:0] mk; logic [31:0] wd; logic vb;
  } lehp_req_t;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, enable_n = 1, output_enable_n = 1, write_n = 1;
  logic select_one_n = 1, select_two_n = 1, address_qualifier_n = 0, segment_select = 0, match_in_n = 1;
  logic full_in_n = 1, validity_line_n_in = 1, slow = 0, hit = 0, wrote = 0, rdValidN = 0;
  logic [7:0] paddr = 0;
  logic [12:0] addr_ctrl_bus = 0, resAddr = 0, ac, coreAddr, coreResAddr;
  logic [31:0] pwdata = 0, data_lines_in = 0, rdData = 0, prdata, data_lines_out, coreWData, coreRdData, rd, dout, d;
  logic pready, pslverr, data_lines_oe, validity_line_n_out, validity_line_oe, active_address_oe, coreReq, coreDirect;
  logic coreSeg, coreWrite, coreValidN, coreDone, coreHit, coreMultiN, coreFullN, coreWrote, coreRdValidN, err, doe, vout;
  logic [16:0] active_address_out;
  logic [5:0] coreOp;
  logic [2:0] coreMask;
  logic [3:0] pg;
  int miscompares = 0, n_tests = 0;
  lehp_req_t expq[$];
  always #50 clock = ~clock;
  lehp_host_port lehp_host_port_i (.*);
  lehp_core_model lehp_core_model_i (.*);
  task give_verdict;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k = 0;
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 0;
    @(posedge clock);
    penable <= 1;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin miscompares++; give_verdict(); end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic pin(input logic w, q, s, input logic [12:0] a, input logic [31:0] dd, input logic v);
    @(posedge clock);
    write_n <= !w; address_qualifier_n <= q; segment_select <= s;
    addr_ctrl_bus <= a; data_lines_in <= dd; validity_line_n_in <= v; enable_n <= 0;
    repeat (10) @(posedge clock);
    dout = data_lines_out; doe = data_lines_oe; vout = validity_line_oe ? validity_line_n_out : 1'bz;
    enable_n <= 1;
    repeat (8) @(posedge clock);
  endtask : pin
  function automatic void ex(logic dr, wr, sg, cw, logic [12:0] a, logic [5:0] op, logic [2:0] mk,
                             logic [31:0] wd, logic vb);
    expq.push_back(lehp_req_t'({dr, wr, sg, cw, a, op, mk, wd, vb}));
  endfunction : ex
  // Reference model: every core request must match the oldest expected one
  always @(posedge clock) begin : mon
    lehp_req_t e;
    if (coreReq === 1'b1) begin
      if (expq.size() == 0) `CHK("spurious_req", 1'b0, coreReq)
      else begin
        e = expq.pop_front();
        `CHK("direct", e.dr, coreDirect)
        `CHK("write", e.wr, coreWrite)
        `CHK("seg", e.sg, coreSeg)
        if (e.dr) `CHK("addr", e.ad, coreAddr)
        if (!e.dr) `CHK("op", e.op, coreOp)
        if (!e.dr) `CHK("mask", e.mk, coreMask)
        if (e.cw) `CHK("wdata", e.wd, coreWData)
        if (e.dr && e.wr) `CHK("valid", e.vb, coreValidN)
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h5bb5));
    repeat (20) @(posedge clock);
    rst <= 0;
    `CHK("aa_rst", 17'h1ffff, active_address_out)
    `CHK("aaoe_rst", 1'b0, active_address_oe)
    apb(0, `LEHP_OFF_CONFIG, 0);
    `CHK("cfg_rst", `LEHP_CFG_RESET, rd)
    apb(0, `LEHP_OFF_DEVSEL, 0);
    `CHK("ds_rst", `LEHP_DS_RESET, rd)
    apb(1, 8'h10, 32'hffff_ffff);
    apb(0, 8'h10, 0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, rd)
    pg = 4'($urandom);
    apb(1, `LEHP_OFF_CONFIG, {6'h0, 1'b1, 21'h0, pg});
    apb(0, `LEHP_OFF_CONFIG, 0);
    `CHK("cfg_rb", {6'h0, 1'b1, 21'h0, pg}, rd)
    output_enable_n <= 0;
    pin(1, 0, 0, 13'h5, 32'h1, 0); // Deselected, must be ignored
    select_one_n <= 0; // Single device selected
    repeat (3) begin
      ac = 13'($urandom);
      resAddr = ac;
      d = $urandom;
      ex(1, 1, d[31], 1, ac, 0, 0, d, d[30]);
      pin(1, 0, d[31], ac, d, d[30]);
      `CHK("aa_wr", {pg, ac}, active_address_out)
      `CHK("aaoe_wr", 1'b1, active_address_oe)
      rdData = $urandom; rdValidN = d[29]; slow = d[28];
      ex(1, 0, d[31], 0, ac, 0, 0, 0, 0);
      pin(0, 0, d[31], ac, ~d, 1);
      `CHK("rd_data", rdData, dout)
      `CHK("rd_oe", 1'b1, doe)
      `CHK("rd_valid", rdValidN, vout)
    end
    select_one_n <= 1; select_two_n <= 0;
    ex(1, 1, 0, 1, 13'h7, 0, 0, d, 0);
    pin(1, 0, 0, 13'h7, d, 0);
    select_two_n <= 1;
    apb(1, `LEHP_OFF_DEVSEL, {28'h0, pg});
    ex(1, 1, 1, 1, 13'h9, 0, 0, d, 1);
    pin(1, 0, 1, 13'h9, d, 1);
    apb(1, `LEHP_OFF_DEVSEL, {28'h0, pg + 4'h1});
    pin(1, 0, 1, 13'h9, d, 1); // Page mismatch, must be ignored
    select_one_n <= 0;
    for (int i = 0; i < 4; i++) begin
      resAddr = 13'($urandom); hit = i[0]; wrote = i[0]; full_in_n <= i[0]; d = $urandom;
      ac = {4'h0, 3'(i + 1), i < 2 ? `LEHP_OP_CMP : `LEHP_OP_WR_NF};
      ex(0, 1, 0, 1, ac, ac[5:0], ac[8:6], d, 0);
      pin(1, 1, 0, ac, d, 0);
      `CHK("aa_res", i[0] ? {pg, resAddr} : 17'h1ffff, active_address_out)
      `CHK("aaoe_res", 1'b1, active_address_oe)
    end
    full_in_n <= 1;
    apb(1, `LEHP_OFF_CONFIG, {4'h0, 2'h1, 1'b1, 21'h0, pg});
    ac = {4'h0, 3'h2, `LEHP_OP_TOP};
    ex(0, 0, 1, 0, ac, `LEHP_OP_TOP, 3'h2, 0, 0);
    pin(0, 1, 1, ac, 0, 1); // Mixed mode value decodes the pins
    apb(1, `LEHP_OFF_CONFIG, {4'h0, `LEHP_MODE_SOFT, 1'b1, 21'h0, pg});
    ex(0, 0, 1, 0, 0, `LEHP_OP_CMP, 3'h1, 0, 0);
    pin(1, 1, 0, 13'h1fff, {18'h0, 1'b1, 1'b1, 3'h0, 3'h1, `LEHP_OP_CMP}, 0);
    pin(1, 1, 1, 0, {18'h0, 1'b0, 1'b0, 3'h0, 3'h2, `LEHP_OP_MEM_IND}, 0); // Load only
    repeat (2) begin
      d = $urandom;
      ex(0, 1, 0, 1, 0, `LEHP_OP_MEM_IND, 3'h2, d, 0);
      pin(1, 0, 1, 13'($urandom), d, 0);
    end
    pin(0, 1, 0, 0, ~d, 1);
    `CHK("st_page", pg, dout[19:16])
    `CHK("st_oe", 1'b1, doe)
    `CHK("left", 32'h0, expq.size())
    output_enable_n <= 1;
    repeat (6) @(posedge clock);
    `CHK("aaoe_off", 1'b0, active_address_oe)
    give_verdict();
  end
endmodule : lehp_host_port_tb
